// ===== filt_pkg.sv
/*
 * Shared constants and the bus request type for the discrete input filter block.
 * Assumes a single 100 MHz system clock and a classic Wishbone master.
 */
`default_nettype none

package filt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CLK_HZ       = 100_000_000;
    localparam int FILT_STEP_MS = 20;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * FILT_STEP_MS;
    localparam int NUM_POINTS   = 32;
    localparam int GROUP_SIZE   = 8;
    localparam int CNT_W        = 28;
    localparam int LEN_W        = 5;
    localparam int SET_W        = 7;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFS_CFG      = 8'h00;
    localparam logic [7:0] OFS_SETTING  = 8'h04;
    localparam logic [7:0] OFS_INPUTS   = 8'h08;
    localparam logic [7:0] OFS_RAW      = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    localparam int CFG_FLEN_LSB = 0;
    localparam int CFG_SLEN_LSB = 8;
    localparam logic [LEN_W-1:0] AREA_LEN_ON = 5'h10;

    localparam int ST_TB_LOCKED = 0;
    localparam int ST_FILT_ON   = 1;
    localparam int ST_SET_BAD   = 2;
    localparam int ST_NOT_READY = 9;
    localparam int STATUS_USED  = 11;

    localparam int IRQ_TB_ADD  = 0;
    localparam int IRQ_TB_LOST = 1;
    localparam int IRQ_IN_CHG  = 2;
    localparam int IRQ_W       = 3;

    localparam logic [LEN_W-1:0] FLEN_RST    = 5'h00;
    localparam logic [LEN_W-1:0] SLEN_RST    = 5'h00;
    localparam logic [SET_W-1:0] SETTING_RST = 7'h01;
    localparam logic [SET_W-1:0] SETTING_MIN = 7'h01;
    localparam logic [IRQ_W-1:0] MASK_RST    = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

endpackage : filt_pkg

`default_nettype wire

// ===== point_filter.sv
/*
 * One input point: two-stage synchroniser followed by a persistence filter.
 * Assumes the raw level is asynchronous and limit holds steady between writes.
 */
`timescale 1ns/10ps
`default_nettype none

module point_filter #(
    parameter int CNT_W = filt_pkg::CNT_W
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             raw_pin,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  raw_sync,
    output logic                  filtered
);

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             filt;
        logic [CNT_W-1:0] cnt;
    } pt_s;

    pt_s st_ff;
    pt_s nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = raw_pin;
        nxt_st.s2 = st_ff.s1;
        if (!enable) begin
            nxt_st.filt = st_ff.s2;
            nxt_st.cnt  = '0;
        end else if (st_ff.s2 == st_ff.filt) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= limit - CNT_W'(1)) begin
            nxt_st.filt = st_ff.s2;
            nxt_st.cnt  = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign raw_sync = st_ff.s2;
    assign filtered = st_ff.filt;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_PERSIST: assert property (
        $past(enable) && enable && $changed(st_ff.filt)
        |-> $past(st_ff.cnt) == $past(limit) - CNT_W'(1))
        else $error("Filtered input changed before the filter time ran out.");

    AST_BYPASS: assert property (
        !enable |=> st_ff.filt == $past(st_ff.s2))
        else $error("Disabled filter did not pass the raw level through.");

endmodule : point_filter

`default_nettype wire

// ===== discrete_input_filter_status.sv
/*
 * Filter and status logic of a 32-point discrete input module, reached by
 * software over a classic Wishbone slave.
 * Assumes raw inputs and the terminal block lock come straight from pins.
 */
`timescale 1ns/10ps
`default_nettype none

module discrete_input_filter_status #(
    parameter int NUM_POINTS  = filt_pkg::NUM_POINTS,
    parameter int CNT_W       = filt_pkg::CNT_W,
    parameter int TICK_CYCLES = filt_pkg::TICK_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire filt_pkg::wb_req_s     wb_req,
    output logic                       wb_ack,
    output logic [31:0]                wb_dat,
    input  wire logic [NUM_POINTS-1:0] raw_in,
    input  wire logic                  tb_locked_pin,
    output logic [NUM_POINTS-1:0]      filtered_in,
    output logic [15:0]                status_word,
    output logic                       irq
);

    typedef struct packed {
        logic                          ack;
        logic [31:0]                   rdat;
        logic [filt_pkg::LEN_W-1:0]    flen;
        logic [filt_pkg::LEN_W-1:0]    slen;
        logic [filt_pkg::SET_W-1:0]    setting;
        logic                          set_bad;
        logic                          seen;
        logic [CNT_W-1:0]              limit;
        logic                          tb1;
        logic                          tb2;
        logic                          tb3;
        logic [NUM_POINTS-1:0]         prev;
        logic [filt_pkg::IRQ_W-1:0]    irq_stat;
        logic [filt_pkg::IRQ_W-1:0]    irq_mask;
        logic                          irq;
        logic [15:0]                   status;
    } st_s;

    st_s                   st_ff;
    st_s                   nxt_st;
    logic [NUM_POINTS-1:0] filt_q;
    logic [NUM_POINTS-1:0] raw_q;
    logic                  filt_en;
    logic                  ready;
    logic                  access;
    logic                  wr_en;
    logic [7:0]            word_adr;
    logic [31:0]           wdat;
    logic [31:0]           rd_val;
    logic [filt_pkg::IRQ_W-1:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // Byte lanes not selected keep their old contents.
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_POINTS; g++) begin : g_point
            point_filter #(
                .CNT_W (CNT_W)
            ) u_point (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .raw_pin  (raw_in[g]),
                .enable   (filt_en),
                .limit    (st_ff.limit),
                .raw_sync (raw_q[g]),
                .filtered (filt_q[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    assign filt_en  = (st_ff.flen == filt_pkg::AREA_LEN_ON);
    // Ready once a setting has arrived; with the filter off nothing waits for one.
    assign ready    = st_ff.seen || !filt_en;
    assign access   = wb_req.cyc && wb_req.stb;
    // A write lands on the edge where the master sees ack, never earlier.
    assign wr_en    = access && wb_req.we && st_ff.ack;
    assign word_adr = {wb_req.adr[7:2], 2'b00};
    assign wdat     = wb_req.dat;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (word_adr == filt_pkg::OFS_CFG) begin
            rd_val[filt_pkg::CFG_FLEN_LSB +: filt_pkg::LEN_W] = st_ff.flen;
            rd_val[filt_pkg::CFG_SLEN_LSB +: filt_pkg::LEN_W] = st_ff.slen;
        end else if (word_adr == filt_pkg::OFS_SETTING) begin
            rd_val[filt_pkg::SET_W-1:0] = st_ff.setting;
        end else if (word_adr == filt_pkg::OFS_INPUTS) begin
            rd_val[NUM_POINTS-1:0] = filt_q;
        end else if (word_adr == filt_pkg::OFS_RAW) begin
            rd_val[NUM_POINTS-1:0] = raw_q;
        end else if (word_adr == filt_pkg::OFS_STATUS) begin
            rd_val[15:0] = st_ff.status;
        end else if (word_adr == filt_pkg::OFS_IRQ_STAT) begin
            rd_val[filt_pkg::IRQ_W-1:0] = st_ff.irq_stat;
        end else if (word_adr == filt_pkg::OFS_IRQ_MASK) begin
            rd_val[filt_pkg::IRQ_W-1:0] = st_ff.irq_mask;
        end else begin
            rd_val = 32'h0000_0000;
        end
    end

    always_comb begin
        events = '0;
        events[filt_pkg::IRQ_TB_ADD]  = st_ff.tb2 && !st_ff.tb3;
        events[filt_pkg::IRQ_TB_LOST] = !st_ff.tb2 && st_ff.tb3;
        events[filt_pkg::IRQ_IN_CHG]  = |(filt_q ^ st_ff.prev);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] merged;
        logic [filt_pkg::SET_W-1:0] new_set;
        merged  = 32'h0000_0000;
        new_set = '0;
        nxt_st  = st_ff;

        nxt_st.ack  = access && !st_ff.ack;
        nxt_st.rdat = (access && !st_ff.ack) ? rd_val : st_ff.rdat;

        nxt_st.tb1  = tb_locked_pin;
        nxt_st.tb2  = st_ff.tb1;
        nxt_st.tb3  = st_ff.tb2;
        nxt_st.prev = filt_q;

        if (wr_en) begin
            if (word_adr == filt_pkg::OFS_CFG) begin
                merged = lane_merge(rd_val, wdat, wb_req.sel);
                nxt_st.flen = merged[filt_pkg::CFG_FLEN_LSB +: filt_pkg::LEN_W];
                nxt_st.slen = merged[filt_pkg::CFG_SLEN_LSB +: filt_pkg::LEN_W];
            end else if (word_adr == filt_pkg::OFS_SETTING) begin
                merged  = lane_merge(rd_val, wdat, wb_req.sel);
                new_set = merged[filt_pkg::SET_W-1:0];
                // A zero setting is out of range; fall back to the shortest time.
                nxt_st.set_bad = (new_set == '0);
                nxt_st.setting = (new_set == '0) ? filt_pkg::SETTING_MIN : new_set;
                nxt_st.seen    = 1'b1;
            end else if (word_adr == filt_pkg::OFS_IRQ_MASK) begin
                merged = lane_merge(rd_val, wdat, wb_req.sel);
                nxt_st.irq_mask = merged[filt_pkg::IRQ_W-1:0];
            end
        end

        // Write-one-to-clear, with a fresh event winning over the clear.
        if (wr_en && word_adr == filt_pkg::OFS_IRQ_STAT && wb_req.sel[0]) begin
            nxt_st.irq_stat = (st_ff.irq_stat & ~wdat[filt_pkg::IRQ_W-1:0]) | events;
        end else begin
            nxt_st.irq_stat = st_ff.irq_stat | events;
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        // Registering the product keeps the multiplier off the points' compare path.
        // A new limit thus reaches the points two edges after a setting write.
        nxt_st.limit = CNT_W'(st_ff.setting) * CNT_W'(TICK_CYCLES);

        nxt_st.status = 16'h0000;
        if (st_ff.slen == filt_pkg::AREA_LEN_ON) begin
            nxt_st.status[filt_pkg::ST_TB_LOCKED] = st_ff.tb2;
            nxt_st.status[filt_pkg::ST_FILT_ON]   = filt_en;
            nxt_st.status[filt_pkg::ST_SET_BAD]   = st_ff.set_bad;
            nxt_st.status[filt_pkg::ST_NOT_READY] = !ready;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff          <= '0;
            st_ff.flen     <= filt_pkg::FLEN_RST;
            st_ff.slen     <= filt_pkg::SLEN_RST;
            st_ff.setting  <= filt_pkg::SETTING_RST;
            st_ff.irq_mask <= filt_pkg::MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wb_ack      = st_ff.ack;
    assign wb_dat      = st_ff.rdat;
    assign filtered_in = filt_q;
    assign status_word = st_ff.status;
    assign irq         = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_STATUS_OFF: assert property (
        st_ff.slen != filt_pkg::AREA_LEN_ON |=> status_word == 16'h0000)
        else $error("Status word returned while status length is not 16.");

    AST_STATUS_TOP: assert property (
        status_word[15:filt_pkg::STATUS_USED] == 5'h00)
        else $error("Upper status bits are not zero.");

    AST_NOT_READY: assert property (
        st_ff.slen == filt_pkg::AREA_LEN_ON
        |=> status_word[filt_pkg::ST_NOT_READY] == $past(!ready))
        else $error("Not-ready bit does not show the inverted ready state.");

    AST_TB_BIT: assert property (
        st_ff.slen == filt_pkg::AREA_LEN_ON
        |=> status_word[filt_pkg::ST_TB_LOCKED] == $past(st_ff.tb2))
        else $error("Status word does not report the terminal block lock.");

    AST_TB_ADD: assert property (
        st_ff.tb2 && !st_ff.tb3 |=> st_ff.irq_stat[filt_pkg::IRQ_TB_ADD])
        else $error("Terminal block added event was lost.");

    AST_TB_LOST: assert property (
        !st_ff.tb2 && st_ff.tb3 |=> st_ff.irq_stat[filt_pkg::IRQ_TB_LOST])
        else $error("Terminal block lost event was lost.");

    AST_FILT_TIME: assert property (
        wr_en && word_adr == filt_pkg::OFS_SETTING && wb_req.sel[0]
        && wdat[6:0] == 7'h0A
        |-> ##2 st_ff.limit == CNT_W'(10) * CNT_W'(TICK_CYCLES))
        else $error("Filter time is not ten steps of 20 ms.");

    AST_BYPASS_CFG: assert property (
        !filt_en |=> filtered_in == $past(raw_q))
        else $error("Raw levels not passed through with the filter off.");

    // A zero setting would make the limit zero and the counter compare wrap.
    AST_SET_RANGE: assert property (
        st_ff.setting != 7'h00)
        else $error("Filter setting held at zero.");

    AST_STATUS_FILT: assert property (
        st_ff.slen == filt_pkg::AREA_LEN_ON
        |=> status_word[filt_pkg::ST_FILT_ON] == $past(filt_en))
        else $error("Status word does not report the filter state.");

    AST_STATUS_SPARE: assert property (
        status_word[8:3] == 6'h00 && !status_word[10])
        else $error("Unassigned status bits are not zero.");

    AST_READY_SEEN: assert property (
        wr_en && word_adr == filt_pkg::OFS_SETTING
        && st_ff.slen == filt_pkg::AREA_LEN_ON
        |-> ##2 !status_word[filt_pkg::ST_NOT_READY])
        else $error("Not-ready bit still set after a setting was written.");

    // Write-one-to-clear must not lose an event that is not being cleared.
    AST_IRQ_STICKY: assert property (
        st_ff.irq_stat[filt_pkg::IRQ_TB_ADD]
        && !(wr_en && word_adr == filt_pkg::OFS_IRQ_STAT && wb_req.sel[0])
        |=> st_ff.irq_stat[filt_pkg::IRQ_TB_ADD])
        else $error("Terminal block added flag cleared without a write.");

    AST_LOST_STICKY: assert property (
        st_ff.irq_stat[filt_pkg::IRQ_TB_LOST]
        && !(wr_en && word_adr == filt_pkg::OFS_IRQ_STAT && wb_req.sel[0])
        |=> st_ff.irq_stat[filt_pkg::IRQ_TB_LOST])
        else $error("Terminal block lost flag cleared without a write.");

    // The output is registered together with the flags, so they always agree.
    AST_IRQ_LEVEL: assert property (
        irq == |(st_ff.irq_stat & st_ff.irq_mask))
        else $error("Interrupt output does not match the unmasked flags.");

    // Any filtered change must leave a trace for software to find.
    AST_IN_CHG: assert property (
        filtered_in != st_ff.prev |=> st_ff.irq_stat[filt_pkg::IRQ_IN_CHG])
        else $error("Filtered input change did not raise its event flag.");

endmodule : discrete_input_filter_status

`default_nettype wire

// ===== cpu_bus_model.sv
/*
 * Backplane CPU model: a classic Wishbone master making one access per go.
 * Assumes go is raised only while no access is open and done is low.
 */
`timescale 1ns/10ps
`default_nettype none

module cpu_bus_model (
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    input  wire logic            go,
    input  wire logic            go_we,
    input  wire logic [7:0]      go_adr,
    input  wire logic [31:0]     go_dat,
    input  wire logic            wb_ack,
    input  wire logic [31:0]     wb_dat,
    output var filt_pkg::wb_req_s wb_req,
    output logic                 done,
    output logic [31:0]          rd_dat
);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        done <= 1'b0;
        if (!resetn) begin
            wb_req <= '0;
            rd_dat <= 32'h0000_0000;
        end else if (wb_req.cyc && wb_ack) begin
            // Data is inverted on release so that no stale word looks valid.
            wb_req.cyc <= 1'b0;
            wb_req.stb <= 1'b0;
            wb_req.dat <= ~wb_req.dat;
            rd_dat     <= wb_dat;
            done       <= 1'b1;
        end else if (go && !wb_req.cyc) begin
            wb_req <= '{cyc: 1'b1, stb: 1'b1, we: go_we, adr: go_adr,
                        sel: 4'hF, dat: go_dat};
        end
    end

endmodule : cpu_bus_model

`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench for the discrete input filter block.
 * Assumes a short filter step so that whole filter times fit in the run.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;

    localparam int TICK = 4;

    logic              sys_clk;
    logic              resetn;
    logic              go;
    logic              go_we;
    logic [7:0]        go_adr;
    logic [31:0]       go_dat;
    logic              done;
    logic [31:0]       rd_dat;
    logic              wb_ack;
    logic [31:0]       wb_dat;
    logic [31:0]       raw_in;
    logic [31:0]       filtered_in;
    logic              tb_locked_pin;
    logic [15:0]       status_word;
    logic              irq;
    filt_pkg::wb_req_s wb_req;
    int                mismatches;
    int                n_tests;

    ////////////////////////////////////////////////////////////////////////////
    discrete_input_filter_status #(.TICK_CYCLES(TICK)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat(wb_dat), .raw_in(raw_in), .tb_locked_pin(tb_locked_pin),
        .filtered_in(filtered_in), .status_word(status_word), .irq(irq));

    cpu_bus_model i_cpu (
        .sys_clk(sys_clk), .resetn(resetn), .go(go), .go_we(go_we),
        .go_adr(go_adr), .go_dat(go_dat), .wb_ack(wb_ack), .wb_dat(wb_dat),
        .wb_req(wb_req), .done(done), .rd_dat(rd_dat));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        @(posedge sys_clk);
        go     <= 1'b1;
        go_we  <= we;
        go_adr <= adr;
        go_dat <= dat;
        @(posedge sys_clk);
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (done !== 1'b1) begin
            check("bus done", {31'h0, done}, 32'h1);
            end_sim();
        end
    endtask : bus

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0000_0000);
        check(what, rd_dat, exp);
    endtask : rd

    // Counts edges from the raw change until the filtered point follows.
    task automatic settle(input int k, input logic v, input int exp_n, input string what);
        int n;
        @(posedge sys_clk);
        raw_in <= (raw_in & ~(32'h0000_0001 << k)) | ({31'h0000_0000, v} << k);
        for (n = 1; n < 600; n++) begin
            @(posedge sys_clk);
            #1;
            if (filtered_in[k] === v)
                break;
        end
        check(what, n, exp_n);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("status idle", status_word, 32'h0);
        rd(filt_pkg::OFS_CFG, 32'h0, "cfg rst");
        rd(filt_pkg::OFS_SETTING, 32'h1, "setting rst");
        rd(filt_pkg::OFS_IRQ_MASK, 32'h0, "mask rst");
        rd(8'h1C, 32'h0, "unmapped");
    endtask : t_reset

    task automatic t_pass;
        settle(0, 1'b1, 3, "pass bit0");
        settle(31, 1'b1, 3, "pass bit31");
    endtask : t_pass

    task automatic t_status;
        bus(1'b1, filt_pkg::OFS_CFG, 32'h0000_1010);
        repeat (3) @(posedge sys_clk);
        #1;
        check("status not ready", status_word, 32'h0202);
        rd(filt_pkg::OFS_STATUS, 32'h0202, "status rd");
        bus(1'b1, filt_pkg::OFS_SETTING, 32'h2);
        repeat (3) @(posedge sys_clk);
        #1;
        check("status ready", status_word, 32'h0002);
    endtask : t_status

    task automatic t_filter;
        settle(1, 1'b1, 2 * TICK + 2, "time set2");
        @(posedge sys_clk);
        raw_in[3:2] <= 2'b11;
        repeat (2 * TICK - 2) @(posedge sys_clk);
        raw_in[2] <= 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        check("glitch", filtered_in[3:2], 32'h2);
        bus(1'b1, filt_pkg::OFS_SETTING, 32'h1);
        repeat (3) @(posedge sys_clk);
        settle(1, 1'b0, TICK + 2, "time set1");
        bus(1'b1, filt_pkg::OFS_SETTING, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        check("status bad set", status_word, 32'h0006);
        settle(1, 1'b1, TICK + 2, "time set0");
    endtask : t_filter

    task automatic t_irq;
        bus(1'b1, filt_pkg::OFS_IRQ_STAT, 32'h7);
        rd(filt_pkg::OFS_IRQ_STAT, 32'h0, "stat clr");
        @(posedge sys_clk);
        tb_locked_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check("status lock", status_word, 32'h0007);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(filt_pkg::OFS_IRQ_STAT, 32'h1, "stat add");
        bus(1'b1, filt_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq on", {31'h0, irq}, 32'h1);
        bus(1'b1, filt_pkg::OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq clr", {31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        tb_locked_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(filt_pkg::OFS_IRQ_STAT, 32'h2, "stat lost");
        check("irq lost masked", {31'h0, irq}, 32'h0);
    endtask : t_irq

    task automatic t_modes;
        bus(1'b1, filt_pkg::OFS_SETTING, 32'h0000_000A);
        repeat (3) @(posedge sys_clk);
        settle(1, 1'b0, 10 * TICK + 2, "time set10");
        rd(filt_pkg::OFS_IRQ_STAT, 32'h6, "stat in chg");
        bus(1'b1, filt_pkg::OFS_CFG, 32'h0000_0010);
        repeat (2) @(posedge sys_clk);
        #1;
        check("status off", status_word, 32'h0);
        bus(1'b1, filt_pkg::OFS_CFG, 32'h0000_1000);
        settle(1, 1'b1, 3, "pass again");
        check("status filter off", status_word, 32'h0);
        rd(filt_pkg::OFS_INPUTS, 32'h8000_000B, "inputs rd");
        rd(filt_pkg::OFS_RAW, 32'h8000_000B, "raw rd");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        resetn        = 1'b0;
        go            = 1'b0;
        go_we         = 1'b0;
        go_adr        = 8'h00;
        go_dat        = 32'h0000_0000;
        raw_in        = 32'h0000_0000;
        tb_locked_pin = 1'b0;
        mismatches    = 0;
        n_tests       = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_pass();
        t_status();
        t_filter();
        t_irq();
        t_modes();
        end_sim();
    end

endmodule : tb_top

`default_nettype wire
